// *** include/wdt_susp_pkg.sv ***
// shared constants and types for the watchdog and suspend control block
package wdt_susp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_WATCHDOG_RESTART = 8'h26;
  localparam logic [7:0] ADDR_PROC_STATUS_CONTROL = 8'hff;
  localparam logic [7:0] ADDR_INT_STATUS = 8'hf0;
  localparam logic [7:0] ADDR_INT_MASK = 8'hf1;

  // processor status and control fields
  localparam int PSC_RUN = 0;
  localparam int PSC_IRQ_SENSE = 2;
  localparam int PSC_SUSPEND = 3;
  localparam int PSC_POR = 4;
  localparam int PSC_WDR = 6;

  // value after power-on reset: power-on flag and run bit
  localparam logic [7:0] PSC_POR_VALUE = 8'h11;
  // pattern loaded by a watchdog reset, bit 4 kept from before
  localparam logic [7:0] PSC_WDR_VALUE = 8'h41;
  localparam logic [7:0] PSC_WDR_KEEP = 8'h10;

  // interrupt status / mask fields
  localparam int EV_WATCHDOG = 0;
  localparam int EV_WAKE = 1;
  localparam logic [1:0] INT_RESET_VALUE = 2'h0;

  localparam logic [13:0] RESET_VECTOR = 14'h0000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int WATCHDOG_TIMEOUT_NS = 8000000;
  localparam int RESET_HOLD_NS = 2000000;
  localparam int WAKE_DELAY_NS = 1000000;
  // least time rounds up
  localparam int WATCHDOG_TIMEOUT_CYCLES =
    (WATCHDOG_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_DELAY_CYCLES =
    (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0]
  {
    ST_RELEASE = 3'b000,
    ST_RUN = 3'b001,
    ST_WDR_HOLD = 3'b010,
    ST_SUSPEND = 3'b011,
    ST_WAKE_OSC = 3'b100,
    ST_WAKE_DELAY = 3'b101
  } ctrl_state_t;

  typedef struct packed
  {
    logic s1;
    logic s2;
  } sync_t;

  typedef struct packed
  {
    ctrl_state_t st;
    logic [CNT_W-1:0] watchdog_counter;
    logic [CNT_W-1:0] delay_cnt;
    logic [7:0] psc;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [7:0] rd_data;
    logic irq;
    logic core_reset;
    logic usb_addr_clear;
    logic fetch_start;
    logic [13:0] fetch_address;
    logic osc_enable;
    logic timer_enable;
    logic logic_enable;
    logic irq_defer;
    sync_t port_wake;
    sync_t usb_wake;
    sync_t osc_stable;
  } block_state_t;

endpackage

// *** logic/watchdog_and_suspend_control.sv ***
// watchdog timer, watchdog reset sequencing and suspend control
//
// Overview of operation
// RULE1 - a rollover of the watchdog counter starts a watchdog reset.
// RULE2 - any write to the restart register clears the watchdog counter.
// RULE3 - no clearing write within 8 ms lets the counter roll over.
// RULE4 - a watchdog reset loads status and control with 010X0001.
// RULE5 - the watchdog reset is held 2 ms, then fetch starts at address zero.
// RULE6 - a watchdog reset clears the usb addresses, muting the transmitter.
// RULE7 - firmware ignores the watchdog flag whenever the power-on flag is set.
// RULE8 - suspend turns off all logic but port wake and usb receive.
// RULE9 - in suspend the oscillator, pll, timer and watchdog stop.
// RULE10 - only an enabled port interrupt or usb bus activity ends suspend.
// RULE11 - firmware sets the run bit in the same write as the suspend bit.
// RULE12 - the oscillator restarts at wake; cpu runs 1 ms after it is stable.
// RULE13 - after wake one instruction runs before any interrupt is taken.
// RULE14 - firmware enters suspend by writing suspend and run together.
// RULE15 - firmware leaves no port data bit floating before suspend.
// RULE16 - resets restore defaults, disable interrupts, zero stack pointers.
// RULE17 - the watchdog counter restarts from zero after wake from suspend.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module watchdog_and_suspend_control
  import wdt_susp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = WATCHDOG_TIMEOUT_CYCLES,
  parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter int unsigned WAKE_CYCLES = WAKE_DELAY_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic port_irq_wake,
  input wire logic usb_bus_active,
  input wire logic osc_stable,
  input wire logic irq_enable_sense,
  input wire logic instr_retired,
  output logic [7:0] rd_data,
  output logic irq,
  output logic core_reset,
  output logic usb_addr_clear,
  output logic fetch_start,
  output logic [13:0] fetch_address,
  output logic osc_enable,
  output logic timer_enable,
  output logic logic_enable,
  output logic irq_defer
);

  // ************************************************************
  // helpers
  // ************************************************************
  // true on the last cycle of a count of lim cycles
  // a byte of headroom keeps the compare exact against a 32-bit limit
  function automatic logic last_count(input logic [CNT_W-1:0] cnt,
                                      input int unsigned lim);
    last_count = ({8'h00, cnt} + 32'h1) >= lim;
  endfunction

  function automatic logic [1:0] w1c(input logic [1:0] cur,
                                     input logic [1:0] clr,
                                     input logic [1:0] set);
    // set wins over clear so an event in the clearing cycle survives
    w1c = (cur & ~clr) | set;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  block_state_t cur;
  block_state_t next_cur;

  logic wr_restart;
  logic wr_psc;
  logic wr_status;
  logic wr_mask;
  logic wake_req;
  logic [1:0] events;

  always_comb
  begin
    wr_restart = wr_en && (addr == ADDR_WATCHDOG_RESTART);
    wr_psc = wr_en && (addr == ADDR_PROC_STATUS_CONTROL);
    wr_status = wr_en && (addr == ADDR_INT_STATUS);
    wr_mask = wr_en && (addr == ADDR_INT_MASK);
    // the port interrupt input is already gated by its enables upstream
    wake_req = cur.port_wake.s2 || cur.usb_wake.s2; // RULE10
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_cur = cur;
    events = 2'h0;
    next_cur.fetch_start = 1'b0;
    next_cur.fetch_address = RESET_VECTOR;
    // synchronisers: first stage feeds only the second
    next_cur.port_wake.s1 = port_irq_wake;
    next_cur.port_wake.s2 = cur.port_wake.s1;
    next_cur.usb_wake.s1 = usb_bus_active;
    next_cur.usb_wake.s2 = cur.usb_wake.s1;
    next_cur.osc_stable.s1 = osc_stable;
    next_cur.osc_stable.s2 = cur.osc_stable.s1;
    next_cur.psc[PSC_IRQ_SENSE] = irq_enable_sense;
    if (instr_retired)
    begin
      next_cur.irq_defer = 1'b0; // RULE13
    end

    // software writes
    if (wr_psc)
    begin
      next_cur.psc[PSC_RUN] = wr_data[PSC_RUN];
      // cause flags are cleared by writing one
      if (wr_data[PSC_POR])
      begin
        next_cur.psc[PSC_POR] = 1'b0;
      end
      if (wr_data[PSC_WDR])
      begin
        next_cur.psc[PSC_WDR] = 1'b0;
      end
    end
    if (wr_mask)
    begin
      next_cur.int_mask = wr_data[1:0];
    end

    case (cur.st)
      ST_RELEASE:
      begin
        // core leaves reset and fetches from the reset vector
        next_cur.core_reset = 1'b0;
        next_cur.usb_addr_clear = 1'b0;
        next_cur.fetch_start = 1'b1; // RULE5
        // fresh start after any reset, so firmware gets a full window
        next_cur.watchdog_counter = '0;
        next_cur.st = ST_RUN;
      end
      ST_RUN:
      begin
        if (wr_restart)
        begin
          next_cur.watchdog_counter = '0; // RULE2
        end
        else if (last_count(cur.watchdog_counter, TIMEOUT_CYCLES)) // RULE3
        begin
          // rollover: watchdog reset begins
          next_cur.st = ST_WDR_HOLD; // RULE1
          next_cur.core_reset = 1'b1;
          next_cur.usb_addr_clear = 1'b1; // RULE6
          // the release cycle still holds reset, so the count starts at one
          next_cur.delay_cnt = CNT_W'(1); // RULE5
          next_cur.psc = PSC_WDR_VALUE | (cur.psc & PSC_WDR_KEEP); // RULE4
          next_cur.int_mask = INT_RESET_VALUE; // RULE16
          next_cur.irq_defer = 1'b0;
          events[EV_WATCHDOG] = 1'b1;
        end
        else
        begin
          next_cur.watchdog_counter = cur.watchdog_counter + 1'b1;
        end
        if (wr_psc && wr_data[PSC_SUSPEND] &&
            !last_count(cur.watchdog_counter, TIMEOUT_CYCLES))
        begin
          // everything but port wake and usb receive powers down
          next_cur.st = ST_SUSPEND; // RULE8
          next_cur.psc[PSC_SUSPEND] = 1'b1;
          next_cur.osc_enable = 1'b0; // RULE9
          next_cur.timer_enable = 1'b0;
          next_cur.logic_enable = 1'b0;
        end
      end
      ST_WDR_HOLD:
      begin
        // stack pointers and registers stay cleared while held
        next_cur.delay_cnt = cur.delay_cnt + 1'b1;
        if (last_count(cur.delay_cnt, HOLD_CYCLES)) // RULE5
        begin
          next_cur.st = ST_RELEASE; // RULE16
        end
      end
      ST_SUSPEND:
      begin
        // watchdog frozen; a clear write has no effect here
        // a wake with the run bit clear is dropped and the part sleeps on
        if (wake_req && cur.psc[PSC_RUN]) // RULE11
        begin
          next_cur.st = ST_WAKE_OSC;
          next_cur.osc_enable = 1'b1; // RULE12
        end
      end
      ST_WAKE_OSC:
      begin
        // counted from the synchronised flag: two cycles late, never early
        next_cur.delay_cnt = '0;
        if (cur.osc_stable.s2)
        begin
          next_cur.st = ST_WAKE_DELAY;
        end
      end
      ST_WAKE_DELAY:
      begin
        next_cur.delay_cnt = cur.delay_cnt + 1'b1;
        if (last_count(cur.delay_cnt, WAKE_CYCLES)) // RULE12
        begin
          next_cur.st = ST_RUN;
          next_cur.psc[PSC_SUSPEND] = 1'b0;
          next_cur.timer_enable = 1'b1;
          next_cur.logic_enable = 1'b1;
          next_cur.watchdog_counter = '0; // RULE17
          next_cur.irq_defer = 1'b1; // RULE13
          events[EV_WAKE] = 1'b1;
        end
      end
      default:
      begin
        next_cur.st = ST_RELEASE;
      end
    endcase

    // ************************************************************
    // interrupt status and read port
    // ************************************************************
    next_cur.int_status = w1c(cur.int_status,
                              wr_status ? wr_data[1:0] : 2'h0, events);
    // built from the next values so irq and status change on one edge
    next_cur.irq = |(next_cur.int_status & next_cur.int_mask);

    next_cur.rd_data = 8'h00;
    if (rd_en)
    begin
      case (addr)
        ADDR_PROC_STATUS_CONTROL:
        begin
          // the watchdog flag may read set after power-on; see the por bit
          next_cur.rd_data = cur.psc; // RULE7
        end
        ADDR_INT_STATUS:
        begin
          next_cur.rd_data = {6'h00, cur.int_status};
        end
        ADDR_INT_MASK:
        begin
          next_cur.rd_data = {6'h00, cur.int_mask};
        end
        default:
        begin
          // restart register is write-only, unmapped reads are zero
          next_cur.rd_data = 8'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // constants only: the reset branch never looks at live inputs
      cur <= '0;
      cur.st <= ST_RELEASE;
      cur.psc <= PSC_POR_VALUE;
      cur.int_status <= INT_RESET_VALUE;
      cur.int_mask <= INT_RESET_VALUE;
      cur.core_reset <= 1'b1; // RULE16
      cur.usb_addr_clear <= 1'b1;
      cur.fetch_address <= RESET_VECTOR;
      cur.osc_enable <= 1'b1;
      cur.timer_enable <= 1'b1;
      cur.logic_enable <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign rd_data = cur.rd_data;
  assign irq = cur.irq;
  assign core_reset = cur.core_reset;
  assign usb_addr_clear = cur.usb_addr_clear;
  assign fetch_start = cur.fetch_start;
  assign fetch_address = cur.fetch_address;
  assign osc_enable = cur.osc_enable;
  assign timer_enable = cur.timer_enable;
  assign logic_enable = cur.logic_enable;
  assign irq_defer = cur.irq_defer;

endmodule

`default_nettype wire

// *** tb/wdt_susp_props.sv ***
// assertion checker for the watchdog and suspend control block
`timescale 1ns/10ps
`default_nettype none

module wdt_susp_props
  import wdt_susp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 40,
  parameter int unsigned HOLD_CYCLES = 10,
  parameter int unsigned WAKE_CYCLES = 8
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic port_irq_wake,
  input wire logic usb_bus_active,
  input wire logic osc_stable,
  input wire logic instr_retired,
  input wire logic [7:0] rd_data,
  input wire logic core_reset,
  input wire logic usb_addr_clear,
  input wire logic fetch_start,
  input wire logic [13:0] fetch_address,
  input wire logic osc_enable,
  input wire logic timer_enable,
  input wire logic logic_enable,
  input wire logic irq_defer
);
  // ***
  // helper counters
  // ***
  // run_cnt allows one cycle either way: the core's own clear edge is hidden
  int unsigned run_cnt;
  int unsigned hold_cnt;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || core_reset || !logic_enable ||
        (wr_en && addr == ADDR_WATCHDOG_RESTART))
      run_cnt <= 0;
    else
      run_cnt <= run_cnt + 1;
    if (sys_rst || !core_reset)
      hold_cnt <= 0;
    else
      hold_cnt <= hold_cnt + 1;
  end

  // ***
  // properties
  // ***
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_read_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not idle");
  a_reset_hold: assert property (
    $fell(core_reset) && hold_cnt > 1 |-> hold_cnt == HOLD_CYCLES)
    else $error("watchdog reset hold length wrong");
  a_addr_clear: assert property (core_reset |-> usb_addr_clear)
    else $error("usb addresses not cleared in reset");
  a_timeout_window: assert property (
    // a rise forced by a system reset is not a rollover
    $rose(core_reset) && !$past(sys_rst) |-> run_cnt + 1 >= TIMEOUT_CYCLES &&
    run_cnt <= TIMEOUT_CYCLES + 1)
    else $error("watchdog rollover at wrong time");
  a_fetch_zero: assert property (
    fetch_start |-> !core_reset && $past(core_reset) &&
    fetch_address == 14'h0000)
    else $error("fetch start wrong");
  a_suspend_off: assert property (
    $fell(logic_enable) |-> !osc_enable && !timer_enable)
    else $error("clocks left running in suspend");
  a_wake_cause: assert property (
    $rose(osc_enable) |-> $past(port_irq_wake, 3) || $past(usb_bus_active, 3))
    else $error("wake without cause");
  a_wake_delay: assert property (
    $rose(logic_enable) |-> $past(osc_stable, WAKE_CYCLES) && irq_defer)
    else $error("wake too early or not deferred");
  a_defer_clear: assert property (
    irq_defer && instr_retired |=> !irq_defer)
    else $error("interrupt deferral not released");
endmodule

bind watchdog_and_suspend_control wdt_susp_props #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)
) props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .port_irq_wake(port_irq_wake),
  .usb_bus_active(usb_bus_active), .osc_stable(osc_stable),
  .instr_retired(instr_retired), .rd_data(rd_data),
  .core_reset(core_reset), .usb_addr_clear(usb_addr_clear),
  .fetch_start(fetch_start), .fetch_address(fetch_address),
  .osc_enable(osc_enable), .timer_enable(timer_enable),
  .logic_enable(logic_enable), .irq_defer(irq_defer)
);
`default_nettype wire

// *** tb/watchdog_and_suspend_control_tb.sv ***
// self-checking testbench for the watchdog and suspend control block
`timescale 1ns/10ps
`default_nettype none

module watchdog_and_suspend_control_tb
  import wdt_susp_pkg::*;
;
  // short counts keep the run brief; expectations follow them
  localparam int unsigned TO = 40;
  localparam int unsigned HO = 10;
  localparam int unsigned WK = 8;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic port_irq_wake = 1'b0;
  logic usb_bus_active = 1'b0;
  logic osc_stable = 1'b1;
  logic irq_enable_sense = 1'b0;
  logic instr_retired = 1'b0;
  logic [7:0] rd_data;
  logic irq, core_reset, usb_addr_clear, fetch_start, irq_defer;
  logic osc_enable, timer_enable, logic_enable;
  logic [13:0] fetch_address;
  int num_errors = 0;
  int total_checks = 0;

  watchdog_and_suspend_control #(.TIMEOUT_CYCLES(TO), .HOLD_CYCLES(HO),
    .WAKE_CYCLES(WK)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .port_irq_wake(port_irq_wake), .usb_bus_active(usb_bus_active),
    .osc_stable(osc_stable), .irq_enable_sense(irq_enable_sense),
    .instr_retired(instr_retired), .rd_data(rd_data), .irq(irq),
    .core_reset(core_reset), .usb_addr_clear(usb_addr_clear),
    .fetch_start(fetch_start), .fetch_address(fetch_address),
    .osc_enable(osc_enable), .timer_enable(timer_enable),
    .logic_enable(logic_enable), .irq_defer(irq_defer));

  always #4 clk_sys = ~clk_sys;

  // ***
  // tasks
  // ***
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // bounded wait: counts edges until s settles at v
  task automatic count_to(ref logic s, input logic v, output logic [13:0] n);
    n = 14'h0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (s !== v && n < 14'h1f4);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ***
  // tests
  // ***
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end

  initial
  begin
    int unsigned i;
    logic [13:0] n;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_PROC_STATUS_CONTROL, 8'h11);
    rd(ADDR_INT_MASK, 8'h00);
    rd(ADDR_WATCHDOG_RESTART, 8'h00);
    rd(8'h33, 8'h00);
    irq_enable_sense <= 1'b1;
    rd(ADDR_PROC_STATUS_CONTROL, 8'h15);
    irq_enable_sense <= 1'b0;
    wr(ADDR_PROC_STATUS_CONTROL, 8'h11);
    for (i = 0; i < 6; i++)
    begin
      wr(ADDR_WATCHDOG_RESTART, i[7:0] ^ 8'ha5);
      repeat (TO - 10) @(posedge clk_sys);
    end
    chk(core_reset, 1'b0);
    wr(ADDR_WATCHDOG_RESTART, 8'h00);
    count_to(core_reset, 1'b1, n);
    chk(n, 14'(TO));
    chk(usb_addr_clear, 1'b1);
    count_to(core_reset, 1'b0, n);
    chk(n, 14'(HO));
    chk({1'b0, fetch_start, fetch_address}, 16'h4000);
    rd(ADDR_PROC_STATUS_CONTROL, 8'h41);
    for (i = 0; i < 2; i++)
    begin
      wr(ADDR_PROC_STATUS_CONTROL, 8'h41);
      wr(ADDR_INT_MASK, 8'h02);
      wr(ADDR_PROC_STATUS_CONTROL, 8'h09);
      osc_stable <= 1'b0;
      #1;
      chk({osc_enable, timer_enable, logic_enable}, 14'h0);
      rd(ADDR_PROC_STATUS_CONTROL, 8'h09);
      repeat (TO + 20) @(posedge clk_sys);
      chk({core_reset, osc_enable}, 14'h0);
      if (i == 0)
        port_irq_wake <= 1'b1;
      else
        usb_bus_active <= 1'b1;
      count_to(osc_enable, 1'b1, n);
      chk(n, 14'h3);
      port_irq_wake <= 1'b0;
      usb_bus_active <= 1'b0;
      repeat (5) @(posedge clk_sys);
      osc_stable <= 1'b1;
      count_to(logic_enable, 1'b1, n);
      chk(n, 14'(3 + WK));
      chk({irq_defer, timer_enable}, 14'h3);
      @(posedge clk_sys);
      instr_retired <= 1'b1;
      @(posedge clk_sys);
      instr_retired <= 1'b0;
      #1;
      chk({irq_defer, irq}, 14'h1);
      count_to(core_reset, 1'b1, n);
      chk(n, 14'(TO - 2));
      count_to(core_reset, 1'b0, n);
      chk(irq, 1'b0);
    end
    rd(ADDR_INT_STATUS, 8'h03);
    wr(ADDR_INT_STATUS, 8'h03);
    rd(ADDR_INT_STATUS, 8'h00);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_PROC_STATUS_CONTROL, 8'h11);
    close_out();
  end
endmodule
`default_nettype wire
